// ### src/ssd_sequencer.sv
// status text display sequencer: chooses the screen the text panel shows
`timescale 1ns/1ps
module ssd_sequencer #(
  parameter int TICK_CYCLES = ssd_pkg::CYCLES_PER_TICK
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // sensor state
  input wire logic boot_active_i,
  input wire logic cfg_present_i,
  input wire logic cfg_req_i,
  input wire logic cfg_confirm_i,
  input wire logic cfg_xfer_i,
  input wire logic ping_i,
  input wire logic field_free_i,
  input wire logic [7:0] field_pair_i,
  input wire logic signed [7:0] incl_h_i,
  input wire logic signed [7:0] incl_v_i,
  // messages
  input wire logic msg_valid_i,
  input wire logic msg_locking_i,
  input wire logic [1:0] msg_scope_i,
  input wire logic [2:0] msg_class_i,
  input wire logic [9:0] msg_code_i,
  // display settings
  input wire logic blank_cfg_i,
  input wire logic rotate_cfg_i,
  // panel
  output ssd_pkg::ssd_screen_t disp_screen_o,
  output logic disp_blank_o,
  output logic disp_rotate_o,
  output logic [7:0] disp_field_pair_o,
  output logic [7:0] disp_axis_h_o,
  output logic signed [7:0] disp_incl_h_o,
  output logic [7:0] disp_axis_v_o,
  output logic signed [7:0] disp_incl_v_o,
  output logic [1:0] disp_prefix_o,
  output logic [7:0] disp_class_o,
  output logic [9:0] disp_code_o,
  // status
  output logic recovery_o,
  output logic fault_latched_o
);

  // ==========================================
  // helpers
  function automatic logic [7:0] class_letter(input logic [2:0] cls);
    case (cls)
      ssd_pkg::CLASS_FAILURE: class_letter = ssd_pkg::LETTER_FAILURE;
      ssd_pkg::CLASS_EXTERNAL: class_letter = ssd_pkg::LETTER_EXTERNAL;
      ssd_pkg::CLASS_USAGE: class_letter = ssd_pkg::LETTER_USAGE;
      ssd_pkg::CLASS_INFO: class_letter = ssd_pkg::LETTER_INFO;
      ssd_pkg::CLASS_PARAM: class_letter = ssd_pkg::LETTER_PARAM;
      default: class_letter = ssd_pkg::LETTER_NONE;
    endcase
  endfunction

  function automatic ssd_pkg::ssd_screen_t boot_screen(input logic cfg, input logic [2:0] idx);
    boot_screen = ssd_pkg::SCR_TYPE;
    case (idx)
      3'h0: boot_screen = ssd_pkg::SCR_TYPE;
      3'h1: boot_screen = ssd_pkg::SCR_SERIAL;
      3'h2: boot_screen = ssd_pkg::SCR_NAME;
      3'h3: boot_screen = cfg ? ssd_pkg::SCR_ADDR_MODE : ssd_pkg::SCR_SETUP_NEEDED;
      3'h4: boot_screen = ssd_pkg::SCR_WIRELESS;
      3'h5: boot_screen = ssd_pkg::SCR_CFG_DATE;
      3'h6: boot_screen = ssd_pkg::SCR_SIGNATURE;
      3'h7: boot_screen = ssd_pkg::SCR_INCLINE;
      default: boot_screen = ssd_pkg::SCR_TYPE;
    endcase
  endfunction

  // ==========================================
  // second tick
  logic tick;

  ssd_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );

  // ==========================================
  // state and counters
  ssd_pkg::ssd_state_t state;
  ssd_pkg::ssd_state_t next_state;
  logic blocked;
  logic pending;
  logic err_active;
  logic [3:0] rec_cnt;
  logic [3:0] free_cnt;
  logic [3:0] step_cnt;
  logic [2:0] boot_idx;
  logic [1:0] msg_scope;
  logic [2:0] msg_class;
  logic [9:0] msg_code;

  wire lock_event = msg_valid_i && msg_locking_i;
  // a latched blocking fault ignores later messages, so no timed recovery may start behind it
  wire err_event = msg_valid_i && !msg_locking_i && !blocked && (msg_class_i != ssd_pkg::CLASS_INFO);
  wire rec_done = err_active && tick && (rec_cnt == ssd_pkg::RECOVERY_S - 4'h1);
  wire free_done = (free_cnt == ssd_pkg::FIELD_FREE_S);
  wire step_done = tick && (step_cnt == ssd_pkg::BOOT_STEP_S - 4'h1);
  wire [2:0] boot_last = cfg_present_i ? ssd_pkg::BOOT_LAST_CFG : ssd_pkg::BOOT_LAST_NOCFG;
  wire in_boot = (state == ssd_pkg::ST_BOOT);
  // without a configuration the incline readout is the resting screen
  wire ssd_pkg::ssd_state_t home = cfg_present_i ? ssd_pkg::ST_NORMAL : ssd_pkg::ST_INCL;

  always_comb begin
    next_state = state;
    if (blocked || lock_event) begin
      next_state = ssd_pkg::ST_BLOCK;
    end else if (cfg_xfer_i) begin
      next_state = ssd_pkg::ST_XFER;
    end else if (pending || cfg_req_i) begin
      next_state = ssd_pkg::ST_PENDING;
    end else if (msg_valid_i) begin
      next_state = ssd_pkg::ST_MSG;
    end else begin
      case (state)
        ssd_pkg::ST_BOOT: begin
          if (!boot_active_i) begin
            next_state = home;
          end
        end
        ssd_pkg::ST_INCL, ssd_pkg::ST_NORMAL: begin
          if (ping_i) begin
            next_state = ssd_pkg::ST_LOCATE;
          end
        end
        ssd_pkg::ST_PENDING, ssd_pkg::ST_XFER: next_state = home;
        ssd_pkg::ST_LOCATE, ssd_pkg::ST_MSG: begin
          if (free_done) begin
            next_state = home;
          end
        end
        ssd_pkg::ST_BLOCK: next_state = ssd_pkg::ST_BLOCK;
        default: next_state = ssd_pkg::ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ssd_pkg::ST_BOOT;
      blocked <= 1'b0;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      // only a power cycle clears a blocking fault
      blocked <= blocked || lock_event;
      // a new request in the confirm cycle wins
      pending <= cfg_req_i || (pending && !cfg_confirm_i);
    end
  end

  // recovery never restarts the machine; it only clears err_active and pulses recovery_o, and the shown message stays
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_active <= 1'b0;
      rec_cnt <= 4'h0;
      recovery_o <= 1'b0;
    end else begin
      err_active <= err_event || (err_active && !rec_done);
      rec_cnt <= (err_event || rec_done) ? 4'h0 : (err_active && tick) ? rec_cnt + 4'h1 : rec_cnt;
      recovery_o <= rec_done && !err_event;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      free_cnt <= 4'h0;
      step_cnt <= 4'h0;
      boot_idx <= 3'h0;
    end else begin
      free_cnt <= !field_free_i ? 4'h0 : (tick && !free_done) ? free_cnt + 4'h1 : free_cnt;
      step_cnt <= (!in_boot || step_done) ? 4'h0 : tick ? step_cnt + 4'h1 : step_cnt;
      if (!in_boot) begin
        boot_idx <= 3'h0;
      end else if (step_done) begin
        boot_idx <= (boot_idx >= boot_last) ? 3'h0 : boot_idx + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      msg_scope <= ssd_pkg::SCOPE_DEVICE;
      msg_class <= ssd_pkg::CLASS_INFO;
      msg_code <= 10'h000;
    end else if (msg_valid_i && !blocked) begin
      msg_scope <= msg_scope_i;
      msg_class <= msg_class_i;
      msg_code <= msg_code_i;
    end
  end

  // ==========================================
  // panel outputs
  ssd_pkg::ssd_screen_t next_screen;

  always_comb begin
    case (state)
      ssd_pkg::ST_BOOT: next_screen = boot_screen(cfg_present_i, boot_idx);
      ssd_pkg::ST_INCL: next_screen = ssd_pkg::SCR_INCLINE;
      ssd_pkg::ST_NORMAL: next_screen = ssd_pkg::SCR_FIELD_PAIR;
      ssd_pkg::ST_PENDING: next_screen = ssd_pkg::SCR_SETUP_PENDING;
      ssd_pkg::ST_XFER: next_screen = ssd_pkg::SCR_SETUP_TRANSFER;
      ssd_pkg::ST_LOCATE: next_screen = ssd_pkg::SCR_LOCATE;
      ssd_pkg::ST_MSG, ssd_pkg::ST_BLOCK: next_screen = ssd_pkg::SCR_MESSAGE;
      default: next_screen = ssd_pkg::SCR_TYPE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      disp_screen_o <= ssd_pkg::SCR_TYPE;
      disp_blank_o <= 1'b0;
      disp_rotate_o <= 1'b0;
      disp_field_pair_o <= 8'h00;
      disp_axis_h_o <= ssd_pkg::AXIS_H_LETTER;
      disp_axis_v_o <= ssd_pkg::AXIS_V_LETTER;
      disp_incl_h_o <= 8'sh00;
      disp_incl_v_o <= 8'sh00;
      disp_prefix_o <= ssd_pkg::SCOPE_DEVICE;
      disp_class_o <= ssd_pkg::LETTER_INFO;
      disp_code_o <= 10'h000;
      fault_latched_o <= 1'b0;
    end else begin
      disp_screen_o <= next_screen;
      disp_blank_o <= blank_cfg_i;
      disp_rotate_o <= rotate_cfg_i;
      disp_field_pair_o <= field_pair_i;
      disp_axis_h_o <= ssd_pkg::AXIS_H_LETTER;
      disp_axis_v_o <= ssd_pkg::AXIS_V_LETTER;
      disp_incl_h_o <= incl_h_i;
      disp_incl_v_o <= incl_v_i;
      disp_prefix_o <= msg_scope;
      disp_class_o <= class_letter(msg_class);
      disp_code_o <= msg_code;
      fault_latched_o <= blocked;
    end
  end

  // ==========================================
  // checks
  AST_BLOCK_STICKY: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    lock_event |=> (state == ssd_pkg::ST_BLOCK) ##1 (fault_latched_o && disp_screen_o == ssd_pkg::SCR_MESSAGE)[*3])
    else $error("blocking fault did not latch");
  AST_XFER_SCREEN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (cfg_xfer_i && !blocked && !lock_event) |=> ##1 disp_screen_o == ssd_pkg::SCR_SETUP_TRANSFER)
    else $error("transfer text not shown");
  AST_PENDING_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (pending && !cfg_confirm_i) |=> pending)
    else $error("pending dropped before confirm");
  AST_RECOVERY_BOUND: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    rec_cnt <= ssd_pkg::RECOVERY_S - 4'h1)
    else $error("recovery count overran");
  AST_RECOVERY_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    recovery_o |-> !err_active && $past(err_active))
    else $error("recovery pulse without error");
  AST_FREE_RETURN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state == ssd_pkg::ST_MSG && free_done && !msg_valid_i && !cfg_xfer_i && !pending && !cfg_req_i && !blocked)
    |=> state == home)
    else $error("no return home after field free");
  AST_NOCFG_INCLINE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (in_boot && !boot_active_i && !cfg_present_i && !msg_valid_i && !cfg_xfer_i && !pending && !cfg_req_i
     && !blocked) |=> ##1 disp_screen_o == ssd_pkg::SCR_INCLINE)
    else $error("incline not shown after boot");
  AST_BLANK_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ##1 (disp_blank_o == $past(blank_cfg_i) && disp_rotate_o == $past(rotate_cfg_i)))
    else $error("display setting not applied");
  AST_CLASS_LETTER: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (msg_valid_i && !blocked && msg_class_i == ssd_pkg::CLASS_PARAM) |=> ##1 disp_class_o == ssd_pkg::LETTER_PARAM)
    else $error("wrong class letter");
  CVR_BOOT_CFG: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    in_boot && cfg_present_i ##1 state == ssd_pkg::ST_NORMAL);
  CVR_RECOVERY: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) recovery_o);
  CVR_LOCATE: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) state == ssd_pkg::ST_LOCATE);

endmodule

// ### src/ssd_pkg.sv
// constants and types shared by the status text display sequencer
package ssd_pkg;

  // ==========================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SECOND_S = 1;
  localparam int CYCLES_PER_TICK = CLK_HZ * SECOND_S;
  localparam logic [3:0] RECOVERY_S = 4'hA;
  localparam logic [3:0] FIELD_FREE_S = 4'h5;
  localparam logic [3:0] BOOT_STEP_S = 4'h2;

  // ==========================================
  // boot screen list lengths (last index)
  localparam logic [2:0] BOOT_LAST_NOCFG = 3'h3;
  localparam logic [2:0] BOOT_LAST_CFG = 3'h7;

  // ==========================================
  // diagnostic classes and letters
  localparam logic [2:0] CLASS_FAILURE = 3'h0;
  localparam logic [2:0] CLASS_EXTERNAL = 3'h1;
  localparam logic [2:0] CLASS_USAGE = 3'h2;
  localparam logic [2:0] CLASS_INFO = 3'h3;
  localparam logic [2:0] CLASS_PARAM = 3'h4;
  localparam logic [7:0] LETTER_FAILURE = 8'h46;
  localparam logic [7:0] LETTER_EXTERNAL = 8'h45;
  localparam logic [7:0] LETTER_USAGE = 8'h55;
  localparam logic [7:0] LETTER_INFO = 8'h49;
  localparam logic [7:0] LETTER_PARAM = 8'h50;
  localparam logic [7:0] LETTER_NONE = 8'h3F;
  localparam logic [7:0] AXIS_H_LETTER = 8'h48;
  localparam logic [7:0] AXIS_V_LETTER = 8'h56;

  // ==========================================
  // message scope prefixes
  localparam logic [1:0] SCOPE_DEVICE = 2'h0;
  localparam logic [1:0] SCOPE_FUNC_A = 2'h1;
  localparam logic [1:0] SCOPE_FUNC_B = 2'h2;

  // ==========================================
  // screens the panel renders
  typedef enum logic [3:0] {
    SCR_TYPE = 4'h0,
    SCR_SERIAL = 4'h1,
    SCR_NAME = 4'h2,
    SCR_SETUP_NEEDED = 4'h3,
    SCR_ADDR_MODE = 4'h4,
    SCR_WIRELESS = 4'h5,
    SCR_CFG_DATE = 4'h6,
    SCR_SIGNATURE = 4'h7,
    SCR_INCLINE = 4'h8,
    SCR_FIELD_PAIR = 4'h9,
    SCR_SETUP_PENDING = 4'hA,
    SCR_SETUP_TRANSFER = 4'hB,
    SCR_LOCATE = 4'hC,
    SCR_MESSAGE = 4'hD
  } ssd_screen_t;

  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_INCL = 8'h02,
    ST_NORMAL = 8'h04,
    ST_PENDING = 8'h08,
    ST_XFER = 8'h10,
    ST_LOCATE = 8'h20,
    ST_MSG = 8'h40,
    ST_BLOCK = 8'h80
  } ssd_state_t;

endpackage

// ### src/ssd_tick.sv
// one-second tick generator for the display sequencer
`timescale 1ns/1ps
module ssd_tick #(
  parameter int CYCLES = ssd_pkg::CYCLES_PER_TICK
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // tick
  output logic tick_o
);

  logic [31:0] cnt;
  wire last = (cnt == 32'(CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt <= last ? 32'h0 : cnt + 32'h1;
      tick_o <= last;
    end
  end

endmodule

// ### test/ssd_panel_model.sv
// text panel model: logs each change of the screen the sequencer selects and counts recoveries
`timescale 1ns/1ps
module ssd_panel_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // panel side
  input wire logic [3:0] disp_screen_i,
  input wire logic recovery_i
);
  logic [3:0] shown;
  logic [3:0] log_q[$];
  int rec_count;
  // ==========================================
  // rendering
  // only changes are logged, so a screen held for seconds costs one entry
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shown = ssd_pkg::SCR_TYPE;
      log_q.delete();
      rec_count = 0;
    end else begin
      if (disp_screen_i !== shown) begin
        log_q.push_back(disp_screen_i);
      end
      shown = disp_screen_i;
      if (recovery_i === 1'b1) begin
        rec_count++;
      end
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the status text display sequencer
`timescale 1ns/1ps
module testbench;
  // one tick is ten cycles so that seconds stay short
  localparam int TK = 10;
  localparam logic [3:0] BOOT_NC [4] = '{ssd_pkg::SCR_TYPE, ssd_pkg::SCR_SERIAL, ssd_pkg::SCR_NAME,
    ssd_pkg::SCR_SETUP_NEEDED};
  localparam logic [3:0] BOOT_C [8] = '{ssd_pkg::SCR_TYPE, ssd_pkg::SCR_SERIAL, ssd_pkg::SCR_NAME,
    ssd_pkg::SCR_ADDR_MODE, ssd_pkg::SCR_WIRELESS, ssd_pkg::SCR_CFG_DATE, ssd_pkg::SCR_SIGNATURE,
    ssd_pkg::SCR_INCLINE};
  localparam logic [7:0] LET [5] = '{ssd_pkg::LETTER_FAILURE, ssd_pkg::LETTER_EXTERNAL, ssd_pkg::LETTER_USAGE,
    ssd_pkg::LETTER_INFO, ssd_pkg::LETTER_PARAM};
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic boot_active_i = 1'b1, cfg_present_i = 1'b0, cfg_req_i = 1'b0, cfg_confirm_i = 1'b0;
  logic cfg_xfer_i = 1'b0, ping_i = 1'b0, field_free_i = 1'b0, msg_valid_i = 1'b0, msg_locking_i = 1'b0;
  logic blank_cfg_i = 1'b0, rotate_cfg_i = 1'b0;
  logic [7:0] field_pair_i = 8'h00;
  logic signed [7:0] incl_h_i = 8'h00, incl_v_i = 8'h00;
  logic [1:0] msg_scope_i = 2'h0;
  logic [2:0] msg_class_i = 3'h0;
  logic [9:0] msg_code_i = 10'h000;
  ssd_pkg::ssd_screen_t disp_screen_o;
  logic disp_blank_o, disp_rotate_o, recovery_o, fault_latched_o;
  logic [7:0] disp_field_pair_o, disp_axis_h_o, disp_axis_v_o, disp_class_o;
  logic signed [7:0] disp_incl_h_o, disp_incl_v_o;
  logic [1:0] disp_prefix_o;
  logic [9:0] disp_code_o;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 38099;
  int k;
  int r0;
  logic [9:0] code;
  logic [1:0] scope;
  logic [3:0] exp_q[$];

  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  ssd_sequencer #(.TICK_CYCLES(TK)) dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .boot_active_i(boot_active_i), .cfg_present_i(cfg_present_i), .cfg_req_i(cfg_req_i),
    .cfg_confirm_i(cfg_confirm_i), .cfg_xfer_i(cfg_xfer_i), .ping_i(ping_i), .field_free_i(field_free_i),
    .field_pair_i(field_pair_i), .incl_h_i(incl_h_i), .incl_v_i(incl_v_i), .msg_valid_i(msg_valid_i),
    .msg_locking_i(msg_locking_i), .msg_scope_i(msg_scope_i), .msg_class_i(msg_class_i),
    .msg_code_i(msg_code_i), .blank_cfg_i(blank_cfg_i), .rotate_cfg_i(rotate_cfg_i),
    .disp_screen_o(disp_screen_o), .disp_blank_o(disp_blank_o), .disp_rotate_o(disp_rotate_o),
    .disp_field_pair_o(disp_field_pair_o), .disp_axis_h_o(disp_axis_h_o), .disp_incl_h_o(disp_incl_h_o),
    .disp_axis_v_o(disp_axis_v_o), .disp_incl_v_o(disp_incl_v_o), .disp_prefix_o(disp_prefix_o),
    .disp_class_o(disp_class_o), .disp_code_o(disp_code_o), .recovery_o(recovery_o),
    .fault_latched_o(fault_latched_o));

  ssd_panel_model pnl_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .disp_screen_i(disp_screen_o),
    .recovery_i(recovery_o));

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic send(input logic lock, input logic [2:0] cls, input logic [9:0] c, input logic [1:0] s);
    msg_valid_i = 1'b1;
    msg_locking_i = lock;
    msg_class_i = cls;
    msg_code_i = c;
    msg_scope_i = s;
    cyc(1);
    msg_valid_i = 1'b0;
  endtask

  task automatic do_reset(input logic cfg);
    nrst_i = 1'b0;
    boot_active_i = 1'b1;
    cfg_present_i = cfg;
    cyc(5);
    chk(disp_screen_o, ssd_pkg::SCR_TYPE);
    chk(disp_class_o, ssd_pkg::LETTER_INFO);
    chk({disp_code_o, recovery_o, fault_latched_o}, 12'h000);
    nrst_i = 1'b1;
  endtask

  // boot list is predicted from the rules and compared with what the panel was sent
  task automatic boot(input logic cfg);
    int n;
    n = cfg ? 8 : 4;
    do_reset(cfg);
    cyc((n + 2) * 2 * TK);
    exp_q.delete();
    for (int i = 1; i <= n + 1; i++) begin
      exp_q.push_back(cfg ? BOOT_C[i % 8] : BOOT_NC[i % 4]);
    end
    foreach (exp_q[i]) begin
      chk(pnl_u.log_q[i], exp_q[i]);
    end
    boot_active_i = 1'b0;
    cyc(3);
    chk(disp_screen_o, cfg ? ssd_pkg::SCR_FIELD_PAIR : ssd_pkg::SCR_INCLINE);
    field_pair_i = 8'($random(seed));
    incl_h_i = 8'($random(seed));
    incl_v_i = 8'($random(seed));
    cyc(2);
    chk(disp_field_pair_o, field_pair_i);
    chk({disp_axis_h_o, disp_incl_h_o, disp_axis_v_o, disp_incl_v_o},
      {ssd_pkg::AXIS_H_LETTER, incl_h_i, ssd_pkg::AXIS_V_LETTER, incl_v_i});
    $display("test boot cfg=%0d done", cfg);
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  // ==========================================
  // main sequence
  initial begin
    boot(1'b0);
    boot(1'b1);
    cfg_req_i = 1'b1;
    cyc(1);
    cfg_req_i = 1'b0;
    cyc(22);
    chk(disp_screen_o, ssd_pkg::SCR_SETUP_PENDING);
    cfg_confirm_i = 1'b1;
    cyc(1);
    cfg_confirm_i = 1'b0;
    cyc(2);
    chk(disp_screen_o, ssd_pkg::SCR_FIELD_PAIR);
    cfg_xfer_i = 1'b1;
    cyc(3);
    chk(disp_screen_o, ssd_pkg::SCR_SETUP_TRANSFER);
    cfg_xfer_i = 1'b0;
    cyc(3);
    chk(disp_screen_o, ssd_pkg::SCR_FIELD_PAIR);
    ping_i = 1'b1;
    cyc(1);
    ping_i = 1'b0;
    cyc(2);
    chk(disp_screen_o, ssd_pkg::SCR_LOCATE);
    $display("test setup and locate done");
    for (k = 0; k < 5; k++) begin
      code = 10'($random(seed));
      scope = 2'({$random(seed)} % 3);
      r0 = pnl_u.rec_count;
      send(1'b0, k[2:0], code, scope);
      cyc(2);
      chk(disp_screen_o, ssd_pkg::SCR_MESSAGE);
      chk(disp_prefix_o, scope);
      chk(disp_class_o, LET[k]);
      chk(disp_code_o, code);
      cyc(82);
      chk(pnl_u.rec_count, r0);
      cyc(25);
      chk(pnl_u.rec_count, r0 + (k != 3));
      field_free_i = 1'b1;
      cyc(35);
      chk(disp_screen_o, ssd_pkg::SCR_MESSAGE);
      cyc(20);
      chk(disp_screen_o, ssd_pkg::SCR_FIELD_PAIR);
      field_free_i = 1'b0;
    end
    $display("test messages done");
    for (k = 0; k < 4; k++) begin
      {blank_cfg_i, rotate_cfg_i} = k[1:0];
      cyc(2);
      chk({disp_blank_o, disp_rotate_o}, k[1:0]);
    end
    $display("test display settings done");
    send(1'b1, ssd_pkg::CLASS_EXTERNAL, 10'h123, ssd_pkg::SCOPE_FUNC_A);
    cyc(2);
    chk({fault_latched_o, disp_code_o}, {1'b1, 10'h123});
    r0 = pnl_u.rec_count;
    send(1'b0, ssd_pkg::CLASS_PARAM, 10'h2AA, ssd_pkg::SCOPE_DEVICE);
    cfg_req_i = 1'b1;
    field_free_i = 1'b1;
    cyc(1);
    cfg_req_i = 1'b0;
    cyc(130);
    chk({disp_screen_o, fault_latched_o, disp_code_o}, {ssd_pkg::SCR_MESSAGE, 1'b1, 10'h123});
    chk(pnl_u.rec_count, r0);
    field_free_i = 1'b0;
    do_reset(1'b1);
    $display("test blocking fault done");
    results();
  end
endmodule
